/* File: hdl/analog_comparator_control.sv */
// Control, status and event logic around an analog voltage comparator.
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_control
(
    // Clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_ARST_N,
    // Register port
    input  wire cmp_ctrl_pkg::bus_req_t I_BUS,
    output logic [cmp_ctrl_pkg::DATA_W-1:0] O_RDATA,
    // Analog comparator outputs, asynchronous
    input  wire logic              I_PIN_ABOVE,
    input  wire logic              I_REF_ABOVE,
    // Analog controls
    output logic                   O_CMP_ENABLE,
    output logic                   O_REF_SELECT,
    // Result output pin
    output logic                   O_RESULT_PIN,
    output logic                   O_RESULT_PIN_OE,
    // Interrupt
    output logic                   O_IRQ
);
    import cmp_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] target);
        hit = (addr == target);
    endfunction

    ctrl_t             ctrl;
    ctrl_t             next_ctrl;
    logic [STAT_W-1:0] irq_stat;
    logic [STAT_W-1:0] next_irq_stat;
    logic [STAT_W-1:0] irq_mask;
    logic [STAT_W-1:0] next_irq_mask;
    logic [DATA_W-1:0] next_rdata;
    logic              prev;
    logic              next_prev;
    logic              next_irq;
    logic              next_pin;
    logic              next_pin_oe;
    logic              cmp_raw;
    logic              cmp_sync;
    logic              rise;
    logic              fall;
    logic              event_hit;
    logic              wr_ctrl;
    logic              wr_mask;
    logic              rd_ctrl;
    logic              rd_stat;
    logic              rd_mask;

    assign wr_ctrl = I_BUS.wr && hit(I_BUS.addr, CTRL_ADDR);
    assign wr_mask = I_BUS.wr && hit(I_BUS.addr, IRQ_MASK_ADDR);
    assign rd_ctrl = I_BUS.rd && hit(I_BUS.addr, CTRL_ADDR);
    assign rd_stat = I_BUS.rd && hit(I_BUS.addr, IRQ_STAT_ADDR);
    assign rd_mask = I_BUS.rd && hit(I_BUS.addr, IRQ_MASK_ADDR);

    // ------------------------------------------------------------
    // Comparator input and synchroniser
    // ------------------------------------------------------------
    // Reference routing
    // Result polarity kept
    // The analog stage reports plus above minus as high; the mux
    // only chooses which plus source that report belongs to.
    assign cmp_raw = ctrl.reference_select ? I_REF_ABOVE : I_PIN_ABOVE;

    cmp_result_sync u_sync
    (
        .I_CLK    (I_CLK),
        .I_ARST_N (I_ARST_N),
        .i_async  (cmp_raw),
        .o_sync   (cmp_sync)
    );

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // Edges while enabled
    // The previous sample keeps tracking while disabled, so turning
    // the block on with the result already high is not an edge.
    assign rise = ctrl.comparator_enable && cmp_sync && !prev;
    assign fall = ctrl.comparator_enable && !cmp_sync && prev;

    always_comb
    begin
        unique case (ctrl.event_edge_select)
            EDGE_FALL_A: event_hit = fall;
            EDGE_RISE:   event_hit = rise;
            EDGE_FALL_B: event_hit = fall;
            EDGE_ANY:    event_hit = rise || fall;
        endcase
    end

    // ------------------------------------------------------------
    // Register next values
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctrl = ctrl;
        next_prev = cmp_sync;
        if (wr_ctrl)
        begin
            next_ctrl.comparator_enable  = I_BUS.wdata[7];
            next_ctrl.reference_select   = I_BUS.wdata[6];
            next_ctrl.compare_irq_enable = I_BUS.wdata[4];
            next_ctrl.result_pin_enable  = I_BUS.wdata[2];
            next_ctrl.event_edge_select  = I_BUS.wdata[1:0];
            if (I_BUS.wdata[5])
            begin
                next_ctrl.compare_event_flag = 1'b0;
            end
        end
        // Event sets flag
        // Setting after the clear lets a same-cycle event win.
        if (event_hit)
        begin
            next_ctrl.compare_event_flag = 1'b1;
        end
        next_ctrl.comparator_result = ctrl.comparator_enable && cmp_sync;
    end

    always_comb
    begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (rd_stat)
        begin
            next_irq_stat = STAT_RESET;
        end
        next_irq_stat[RISE_STAT_BIT] = next_irq_stat[RISE_STAT_BIT] || rise;
        next_irq_stat[FALL_STAT_BIT] = next_irq_stat[FALL_STAT_BIT] || fall;
        if (wr_mask)
        begin
            next_irq_mask = I_BUS.wdata[STAT_W-1:0];
        end
    end

    always_comb
    begin
        next_rdata = DATA_ZERO;
        if (rd_ctrl)
        begin
            next_rdata = ctrl;
        end
        else if (rd_stat)
        begin
            next_rdata[STAT_W-1:0] = irq_stat;
        end
        else if (rd_mask)
        begin
            next_rdata[STAT_W-1:0] = irq_mask;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb
    begin
        next_irq = (next_ctrl.compare_event_flag
                    && next_ctrl.compare_irq_enable)
                   || |(next_irq_stat & next_irq_mask);
        next_pin    = next_ctrl.result_pin_enable
                      && next_ctrl.comparator_result;
        next_pin_oe = next_ctrl.result_pin_enable;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            ctrl            <= CTRL_RESET;
            irq_stat        <= STAT_RESET;
            irq_mask        <= STAT_RESET;
            prev            <= 1'b0;
            O_RDATA         <= DATA_ZERO;
            O_CMP_ENABLE    <= 1'b0;
            O_REF_SELECT    <= 1'b0;
            O_RESULT_PIN    <= 1'b0;
            O_RESULT_PIN_OE <= 1'b0;
            O_IRQ           <= 1'b0;
        end
        else
        begin
            ctrl            <= next_ctrl;
            irq_stat        <= next_irq_stat;
            irq_mask        <= next_irq_mask;
            prev            <= next_prev;
            O_RDATA         <= next_rdata;
            O_CMP_ENABLE    <= next_ctrl.comparator_enable;
            O_REF_SELECT    <= next_ctrl.reference_select;
            O_RESULT_PIN    <= next_pin;
            O_RESULT_PIN_OE <= next_pin_oe;
            O_IRQ           <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_ARST_N);

    sequence s_raw_high;
        (ctrl.comparator_enable && cmp_raw) [*4];
    endsequence

    // A read racing a new edge keeps that edge, so only quiet reads clear both bits.
    sequence s_quiet_status_read;
        rd_stat && !rise && !fall;
    endsequence

    sequence s_flag_write_clear;
        ctrl.compare_event_flag && wr_ctrl && I_BUS.wdata[5] && !event_hit;
    endsequence

    a_read_ctrl_data:
        assert property (rd_ctrl |=> O_RDATA == $past(ctrl))
        else $error("Control read returned wrong data.");

    a_enable_gates_flag:
        assert property (!ctrl.comparator_enable && !ctrl.compare_event_flag
                         |=> !ctrl.compare_event_flag)
        else $error("Event flag set while disabled.");

    a_ref_select_out:
        assert property (ctrl.reference_select |-> O_REF_SELECT)
        else $error("Reference select not driven.");

    a_result_follows:
        assert property (s_raw_high |-> ctrl.comparator_result)
        else $error("Result not high after steady high input.");

    a_rise_sets_flag:
        assert property (ctrl.event_edge_select == EDGE_RISE && rise
                         |=> ctrl.compare_event_flag)
        else $error("Rising event did not set the flag.");

    a_flag_w1c:
        assert property (s_flag_write_clear |=> !ctrl.compare_event_flag)
        else $error("Write one did not clear the flag.");

    a_flag_w0_keep:
        assert property (ctrl.compare_event_flag && wr_ctrl
                         && !I_BUS.wdata[5] |=> ctrl.compare_event_flag)
        else $error("Write zero cleared the flag.");

    a_irq_from_flag:
        assert property (ctrl.compare_event_flag && ctrl.compare_irq_enable
                         |-> O_IRQ)
        else $error("Interrupt missing for enabled flag.");

    a_result_off:
        assert property (!ctrl.comparator_enable |=> !ctrl.comparator_result)
        else $error("Result bit high while disabled.");

    a_pin_disabled:
        assert property (!ctrl.result_pin_enable
                         |-> !O_RESULT_PIN_OE && !O_RESULT_PIN)
        else $error("Pin driven while disabled.");

    a_fall_sets_flag:
        assert property (ctrl.event_edge_select == EDGE_FALL_B && fall
                         |=> ctrl.compare_event_flag)
        else $error("Falling event did not set the flag.");

    a_no_edge_off:
        assert property (!ctrl.comparator_enable |-> !rise && !fall)
        else $error("Edge seen while disabled.");

    a_stat_read_clear:
        assert property (s_quiet_status_read |=> irq_stat == STAT_RESET)
        else $error("Status read did not clear the status bits.");

    a_any_edge_flag:
        assert property (ctrl.event_edge_select == EDGE_ANY && (rise || fall)
                         |=> ctrl.compare_event_flag)
        else $error("Toggle event did not set the flag.");

    a_rdata_idle:
        assert property (!rd_ctrl && !rd_stat && !rd_mask
                         |=> O_RDATA == DATA_ZERO)
        else $error("Read data not zero outside a read.");

endmodule
`default_nettype wire

/* File: hdl/cmp_result_sync.sv */
// Two-stage synchroniser for the asynchronous comparator result.
`timescale 1ns/10ps
`default_nettype none
module cmp_result_sync
(
    // Clock and reset
    input  wire logic I_CLK,
    input  wire logic I_ARST_N,
    // Asynchronous level in, synchronised level out
    input  wire logic i_async,
    output logic      o_sync
);

    logic stage1;
    logic stage2;
    logic next_stage1;
    logic next_stage2;

    // The first stage feeds only the second, so a metastable sample
    // never reaches the edge logic.
    always_comb
    begin
        next_stage1 = i_async;
        next_stage2 = stage1;
    end

    always_ff @(posedge I_CLK or negedge I_ARST_N)
    begin
        if (!I_ARST_N)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
        end
        else
        begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign o_sync = stage2;

endmodule
`default_nettype wire

/* File: pkg/cmp_ctrl_pkg.sv */
// Shared types and constants of the comparator control block.
package cmp_ctrl_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_ADDR     = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h01;
    localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h02;

    // ------------------------------------------------------------
    // Event edge selection codes
    // ------------------------------------------------------------
    localparam logic [1:0] EDGE_FALL_A = 2'h0;
    localparam logic [1:0] EDGE_RISE   = 2'h1;
    localparam logic [1:0] EDGE_FALL_B = 2'h2;
    localparam logic [1:0] EDGE_ANY    = 2'h3;

    // ------------------------------------------------------------
    // Interrupt status layout and reset values
    // ------------------------------------------------------------
    localparam int STAT_W        = 2;
    localparam int RISE_STAT_BIT = 0;
    localparam int FALL_STAT_BIT = 1;
    localparam logic [STAT_W-1:0] STAT_RESET = 2'h0;
    localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

    // One bus request: address, write data and the two strobes.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bus_req_t;

    // Status and control register, most significant field first.
    typedef struct packed {
        logic       comparator_enable;
        logic       reference_select;
        logic       compare_event_flag;
        logic       compare_irq_enable;
        logic       comparator_result;
        logic       result_pin_enable;
        logic [1:0] event_edge_select;
    } ctrl_t;

    localparam ctrl_t CTRL_RESET = 8'h00;

endpackage

/* File: test/analog_comparator_control_tb_top.sv */
// Self-checking testbench of the comparator control block.
`timescale 1ns/10ps
`default_nettype none
module analog_comparator_control_tb_top;
    import cmp_ctrl_pkg::*;
    logic              clk;
    logic              arst_n;
    bus_req_t          bus;
    logic [DATA_W-1:0] rdata;
    logic              pin_above;
    logic              ref_above;
    logic              cmp_en;
    logic              ref_sel;
    logic              res_pin;
    logic              res_oe;
    logic              irq;
    logic [11:0]       plus_mv;
    logic [11:0]       ref_mv;
    logic [11:0]       minus_mv;
    int                bad_count;
    int                n_checks;
    int                cycles;
    int                seed;
    int en, rs, flag, ie, pe, mode, raw, rise_st, fall_st, mask;
    logic [7:0]        d;

    analog_comparator_control i_analog_comparator_control (
        .I_CLK(clk), .I_ARST_N(arst_n), .I_BUS(bus), .O_RDATA(rdata),
        .I_PIN_ABOVE(pin_above), .I_REF_ABOVE(ref_above),
        .O_CMP_ENABLE(cmp_en), .O_REF_SELECT(ref_sel),
        .O_RESULT_PIN(res_pin), .O_RESULT_PIN_OE(res_oe), .O_IRQ(irq));
    cmp_analog_model i_cmp_analog_model (
        .i_plus_mv(plus_mv), .i_ref_mv(ref_mv), .i_minus_mv(minus_mv),
        .o_pin_above(pin_above), .o_ref_above(ref_above));

    always #50 clk = ~clk;

    // A hang costs a mismatch and ends the run.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            bad_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Raw result changes only count as edges while the block is enabled.
    task automatic update_raw();
        int nr;
        nr = rs ? (ref_mv > minus_mv) : (plus_mv > minus_mv);
        if (en && nr != raw)
        begin
            if (nr) rise_st = 1;
            else fall_st = 1;
            if (nr ? (mode == 1 || mode == 3) : (mode != 1)) flag = 1;
        end
        raw = nr;
    endtask

    task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        bus <= '{a, v, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '{8'h00, 8'h00, 1'b0, 1'b0};
        if (a == CTRL_ADDR)
        begin
            en = v[7]; rs = v[6]; ie = v[4]; pe = v[2]; mode = v[1:0];
            if (v[5]) flag = 0;
        end
        if (a == IRQ_MASK_ADDR) mask = v[1:0];
        update_raw();
    endtask

    task automatic bus_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '{8'h00, 8'h00, 1'b0, 1'b0};
        #1 v = rdata;
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic check_all();
        logic [7:0] st;
        int         res;
        res = en & raw;
        st = 8'(fall_st * 2 + rise_st);
        check({7'h0, irq}, 8'((flag & ie) | ((st & mask) != 0)));
        check({7'h0, cmp_en}, 8'(en));
        check({7'h0, ref_sel}, 8'(rs));
        check({7'h0, res_pin}, 8'(res & pe));
        check({7'h0, res_oe}, 8'(pe));
        bus_rd(CTRL_ADDR, d);
        check(d, {en[0], rs[0], flag[0], ie[0], res[0], pe[0], mode[1:0]});
        @(posedge clk) #1 check(rdata, DATA_ZERO);
        bus_rd(IRQ_STAT_ADDR, d);
        check(d, st);
        rise_st = 0;
        fall_st = 0;
        @(posedge clk) #1 check({7'h0, irq}, 8'(flag & ie));
    endtask

    // Moves the analog levels, never letting two compared inputs tie.
    task automatic analog_step();
        logic [11:0] m;
        @(posedge clk);
        m = 12'h400 + 12'($urandom % 1024);
        minus_mv <= m;
        plus_mv <= $urandom % 2 ? m + 12'h010 : m - 12'h010;
        ref_mv <= $urandom % 2 ? m + 12'h008 : m - 12'h008;
        repeat (5) @(posedge clk);
        #1;
        update_raw();
    endtask

    initial
    begin
        clk = 0; arst_n = 0; bus = '{8'h00, 8'h00, 1'b0, 1'b0};
        plus_mv = 12'h100; ref_mv = 12'h100; minus_mv = 12'h200;
        {en, rs, flag, ie, pe, mode, raw, rise_st, fall_st, mask} = '0;
        seed = $urandom(23622);
        repeat (8) @(posedge clk);
        arst_n <= 1;
        #1 check_all();
        $display("test reset values done");
        for (int m = 0; m < 8; m++)
        begin
            d = 8'($urandom) & 8'h1c;
            bus_wr(CTRL_ADDR, d | 8'h20 | 8'(m[2] * 64 + m[1:0]));
            bus_wr(IRQ_MASK_ADDR, 8'($urandom));
            settle();
            bus_wr(CTRL_ADDR, 8'h80 | d | 8'(m[2] * 64 + m[1:0]));
            settle();
            repeat (6)
            begin
                analog_step();
                check_all();
            end
            bus_wr(CTRL_ADDR, 8'h80 | d | 8'(m[2] * 64 + m[1:0]));
            settle();
            check_all();
            bus_wr(CTRL_ADDR, 8'ha0 | d | 8'(m[2] * 64 + m[1:0]));
            settle();
            check_all();
            bus_wr(CTRL_ADDR, d | 8'(m[2] * 64 + m[1:0]));
            analog_step();
            analog_step();
            check_all();
            $display("test mode %0d done", m);
        end
        bus_wr(8'h03, 8'hff);
        bus_wr(IRQ_STAT_ADDR, 8'hff);
        bus_rd(8'h03, d);
        check(d, DATA_ZERO);
        check_all();
        $display("test unmapped access done");
        summarize();
    end
endmodule
`default_nettype wire

/* File: test/cmp_analog_model.sv */
// Behavioural model of the analog comparator that faces the control block.
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model
(
    // Analog levels in millivolts
    input  wire logic [11:0] i_plus_mv,
    input  wire logic [11:0] i_ref_mv,
    input  wire logic [11:0] i_minus_mv,
    // Comparator results, asynchronous
    output logic             o_pin_above,
    output logic             o_ref_above
);
    // Equal inputs give low here; the real circuit is undefined there.
    // result above minus
    assign o_pin_above = i_plus_mv > i_minus_mv;
    assign o_ref_above = i_ref_mv > i_minus_mv;
endmodule
`default_nettype wire
